// ==== core/pdcl_loader.sv ====
`timescale 1ns/1ps
module pdcl_loader
  import pdcl_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           reset_n_in,
  input  wire logic           xtal_in,
  input  wire logic           vco_in,
  input  wire logic           par_load_n_in,
  input  wire logic [M_W-1:0] m_par_in,
  input  wire logic [N_W-1:0] n_par_in,
  input  wire logic           ser_clock_in,
  input  wire logic           ser_data_in,
  input  wire logic           ser_load_in,
  output logic                ref_clk_out,
  output logic                fb_clk_out,
  output logic                synth_clock_out,
  output logic                probe_out,
  output logic [M_W-1:0]      m_cfg_out,
  output logic [N_W-1:0]      n_cfg_out,
  output logic [T_W-1:0]      t_cfg_out
);

  // ---------------------------------------------------------------------
  // Pin synchronisers: three stages, a change counts when 2 and 3 agree.
  // ---------------------------------------------------------------------
  logic [4:0]  sync1;
  logic [4:0]  sync2;
  logic [4:0]  sync3;
  logic [4:0]  pin_raw;
  logic [4:0]  stable;
  logic [4:0]  next_stable;
  logic [M_W-1:0] m_s1, m_s2, m_s3, m_in;
  logic [N_W-1:0] n_s1, n_s2, n_s3, n_in;

  assign pin_raw = {xtal_in, vco_in, par_load_n_in, ser_clock_in,
                    ser_load_in};

  // Filter on agreement of the two later stages only.
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_filt
      always_comb begin
        next_stable[gi] = (sync2[gi] == sync3[gi]) ? sync3[gi] : stable[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1  <= '0;
      sync2  <= '0;
      sync3  <= '0;
      stable <= '0;
      m_s1   <= M_RESET;
      m_s2   <= M_RESET;
      m_s3   <= M_RESET;
      n_s1   <= N_RESET;
      n_s2   <= N_RESET;
      n_s3   <= N_RESET;
    end else begin
      sync1  <= pin_raw;
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= next_stable;
      m_s1   <= m_par_in;
      m_s2   <= m_s1;
      m_s3   <= m_s2;
      n_s1   <= n_par_in;
      n_s2   <= n_s1;
      n_s3   <= n_s2;
    end
  end

  // The data pin is sampled only at a qualified serial clock edge, which
  // lags the pin by four registers (three stages and the filter), so a
  // matching four-register delay keeps the setup relation the host already meets at the pins.
  logic sd1, sd2, sd3, sd4;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sd1 <= 1'b0;
      sd2 <= 1'b0;
      sd3 <= 1'b0;
      sd4 <= 1'b0;
    end else begin
      sd1 <= ser_data_in;
      sd2 <= sd1;
      sd3 <= sd2;
      sd4 <= sd3;
    end
  end

  // Parallel words use the agreed value of the last two stages.
  assign m_in = (m_s2 == m_s3) ? m_s3 : m_cfg_out;
  assign n_in = (n_s2 == n_s3) ? n_s3 : n_cfg_out;

  // ---------------------------------------------------------------------
  // Edge detection on the filtered pins.
  // ---------------------------------------------------------------------
  logic [4:0] stable_d;
  logic       xtal_rise, vco_rise, pl_high, pl_rise, sclk_rise, sld_fall;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stable_d <= '0;
    end else begin
      stable_d <= stable;
    end
  end

  assign xtal_rise = stable[4] & ~stable_d[4];
  assign vco_rise  = stable[3] & ~stable_d[3];
  assign pl_high   = stable[2];
  assign pl_rise   = stable[2] & ~stable_d[2];
  assign sclk_rise = stable[1] & ~stable_d[1];
  assign sld_fall  = ~stable[0] & stable_d[0];

  // ---------------------------------------------------------------------
  // Serial shifter and configuration latches.
  // ---------------------------------------------------------------------
  logic [SHIFT_W-1:0] shift;
  logic [SHIFT_W-1:0] next_shift;
  logic [M_W-1:0]     next_m;
  logic [N_W-1:0]     next_n;
  logic [T_W-1:0]     next_t;
  pdcl_state_t        state;
  pdcl_state_t        next_state;

  // The shifter runs regardless of the strobe; only the transfer is gated.
  // Older bits simply fall off the top, so the last fourteen survive.
  always_comb begin
    next_shift = shift;
    if (sclk_rise) begin
      next_shift = {shift[SHIFT_W-2:0], sd4};
    end
  end

  // Strobe low tracks the pins and parks the probe; the rising edge
  // freezes the last tracked value; serial loads apply only when high.
  always_comb begin
    next_m     = m_cfg_out;
    next_n     = n_cfg_out;
    next_t     = t_cfg_out;
    next_state = state;
    case (state)
      PDCL_PAR: begin
        next_m = m_in;
        next_n = n_in;
        next_t = T_STATIC;
        if (pl_rise) begin
          next_state = PDCL_HOLD;
        end
      end
      PDCL_HOLD, PDCL_SER: begin
        if (!pl_high) begin
          next_state = PDCL_PAR;
          next_t     = T_STATIC;
        end else if (sld_fall) begin
          next_m     = shift[M_LSB +: M_W];
          next_n     = shift[N_LSB +: N_W];
          next_t     = shift[T_LSB +: T_W];
          next_state = PDCL_SER;
        end
      end
      default: begin
        next_state = PDCL_PAR;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shift     <= SHIFT_RST;
      m_cfg_out <= M_RESET;
      n_cfg_out <= N_RESET;
      t_cfg_out <= T_STATIC;
      state     <= PDCL_PAR;
    end else begin
      shift     <= next_shift;
      m_cfg_out <= next_m;
      n_cfg_out <= next_n;
      t_cfg_out <= next_t;
      state     <= next_state;
    end
  end

  // ---------------------------------------------------------------------
  // Reference and feedback dividers, counting filtered edges.
  // ---------------------------------------------------------------------
  logic [REF_CNT_W-1:0] ref_cnt, next_ref_cnt;
  logic [M_W-1:0]       fb_cnt, next_fb_cnt;
  logic                 next_ref, next_fb;

  // Reference toggles every eight crystal edges: divide by sixteen.
  always_comb begin
    next_ref_cnt = ref_cnt + 4'h1;
    next_ref     = ref_clk_out;
    if (xtal_rise && ref_cnt == REF_LAST) begin
      next_ref_cnt = '0;
      next_ref     = ~ref_clk_out;
    end else if (!xtal_rise) begin
      next_ref_cnt = ref_cnt;
    end
  end

  // Feedback gives one pulse per M VCO edges; zero behaves as one.
  always_comb begin
    next_fb_cnt = fb_cnt;
    next_fb     = 1'b0;
    if (vco_rise) begin
      if (fb_cnt + M_ONE >= m_cfg_out) begin
        next_fb_cnt = '0;
        next_fb     = 1'b1;
      end else begin
        next_fb_cnt = fb_cnt + M_ONE;
      end
    end
  end

  logic out_div;
  logic next_probe;

  pdcl_out_div u_out_div (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .vco_in     (stable[3]),
    .n_sel_in   (n_cfg_out),
    .div_out    (out_div)
  );

  // Probe mux; zero keeps the pin static for best output jitter.
  always_comb begin
    case (t_cfg_out)
      PROBE_REF:  next_probe = ref_clk_out;
      PROBE_FB:   next_probe = fb_clk_out;
      PROBE_VCO:  next_probe = stable[3];
      PROBE_ONE:  next_probe = 1'b1;
      PROBE_XTAL: next_probe = stable[4];
      PROBE_SCLK: next_probe = stable[1];
      PROBE_OUT:  next_probe = synth_clock_out;
      default:    next_probe = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ref_cnt         <= '0;
      fb_cnt          <= '0;
      ref_clk_out     <= 1'b0;
      fb_clk_out      <= 1'b0;
      synth_clock_out <= 1'b0;
      probe_out       <= 1'b0;
    end else begin
      ref_cnt         <= next_ref_cnt;
      fb_cnt          <= next_fb_cnt;
      ref_clk_out     <= next_ref;
      fb_clk_out      <= next_fb;
      synth_clock_out <= out_div;
      probe_out       <= next_probe;
    end
  end

  // ---------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------
  chk_par_probe_zero: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) (state == PDCL_PAR) |=> t_cfg_out == T_STATIC)
    else $error("probe select not parked while strobe low");
  chk_ser_load_copy: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) (state != PDCL_PAR && pl_high && sld_fall)
    |=> m_cfg_out == $past(shift[M_LSB +: M_W])
        && t_cfg_out == $past(shift[T_LSB +: T_W]))
    else $error("serial load did not copy shifter");
  chk_ser_blocked: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) (state == PDCL_PAR && !pl_rise)
    |=> m_cfg_out == $past(m_in))
    else $error("parallel path not transparent");
  chk_shift_step: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) sclk_rise
    |=> shift == {$past(shift[SHIFT_W-2:0]), $past(sd4)})
    else $error("shifter did not advance");
  chk_shift_hold: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) !sclk_rise |=> $stable(shift))
    else $error("shifter moved without clock");
  chk_par_capture: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) (state == PDCL_PAR && pl_rise)
    |=> state == PDCL_HOLD ##1 (state == PDCL_PAR
        || ($stable(m_cfg_out) && $stable(n_cfg_out)) || $past(sld_fall)))
    else $error("parallel capture not held");
  chk_ref_period: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) (xtal_rise && ref_cnt == REF_LAST)
    |=> ref_clk_out != $past(ref_clk_out))
    else $error("reference did not toggle at count end");
  chk_fb_pulse: assert property (@(posedge clk_in)
    disable iff (!reset_n_in) fb_clk_out |-> $past(vco_rise))
    else $error("feedback pulse without vco edge");

endmodule : pdcl_loader

// ==== core/pdcl_pkg.sv ====
// Overview of operation
// - Crystal divided by sixteen forms reference.
// - Feedback divider divides VCO by M.
// - Output divider gives 1,2,4,8, even duty.
// - Rising parallel strobe captures M and N.
// - Parallel path wins; serial needs strobe high.
// - Fourteen-bit shift register advances per serial clock.
// - Falling serial load copies shifter when strobe high.
// - Probe pin shows node chosen by T bits.
// - M is unsigned nine-bit binary, 200 to 400.
// - Stream order: T, N, M, MSB first.
// - Strobe low makes parallel latches transparent.
// - Strobe low forces probe select to zero.
// - N select 00,01,10,11 divides 1,2,4,8.
package pdcl_pkg;

  // ---------------------------------------------------------------------
  // Widths and field layout of the serial word.
  // ---------------------------------------------------------------------
  localparam int M_W       = 9;
  localparam int N_W       = 2;
  localparam int T_W       = 3;
  localparam int SHIFT_W   = 14;
  localparam int M_LSB     = 0;
  localparam int N_LSB     = 9;
  localparam int T_LSB     = 11;
  localparam int REF_DIV   = 16;
  localparam int REF_CNT_W = 4;
  localparam int OUT_CNT_W = 3;

  // ---------------------------------------------------------------------
  // Reset values and encodings.
  // ---------------------------------------------------------------------
  localparam logic [M_W-1:0]     M_RESET   = 9'h0C8;
  localparam logic [N_W-1:0]     N_RESET   = 2'h0;
  localparam logic [T_W-1:0]     T_STATIC  = 3'h0;
  localparam logic [SHIFT_W-1:0] SHIFT_RST = 14'h0000;
  localparam logic [REF_CNT_W-1:0] REF_LAST = 4'h7;
  localparam logic [M_W-1:0]     M_ONE     = 9'h001;
  localparam logic [OUT_CNT_W-1:0] OUT_ONE = 3'h1;

  // Probe selections.
  localparam logic [T_W-1:0] PROBE_REF  = 3'h1;
  localparam logic [T_W-1:0] PROBE_FB   = 3'h2;
  localparam logic [T_W-1:0] PROBE_VCO  = 3'h3;
  localparam logic [T_W-1:0] PROBE_ONE  = 3'h4;
  localparam logic [T_W-1:0] PROBE_XTAL = 3'h5;
  localparam logic [T_W-1:0] PROBE_SCLK = 3'h6;
  localparam logic [T_W-1:0] PROBE_OUT  = 3'h7;

  // Load-path state, Gray coded along parallel, hold, serial.
  typedef enum logic [1:0] {
    PDCL_PAR  = 2'h0,
    PDCL_HOLD = 2'h1,
    PDCL_SER  = 2'h3
  } pdcl_state_t;

endpackage : pdcl_pkg

// ==== core/pdcl_out_div.sv ====
`timescale 1ns/1ps
// -----------------------------------------------------------------------
// Output divider: 2, 4 or 8 from a binary counter, 1 passes the VCO level.
// -----------------------------------------------------------------------
module pdcl_out_div
  import pdcl_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           reset_n_in,
  input  wire logic           vco_in,
  input  wire logic [N_W-1:0] n_sel_in,
  output logic                div_out
);

  logic [OUT_CNT_W-1:0] count;
  logic [OUT_CNT_W-1:0] next_count;
  logic                 vco_d;
  logic                 vco_rise;

  // Edges are found here, so that divide by one can pass the level itself.
  assign vco_rise = vco_in & ~vco_d;

  // A binary counter's bit k toggles at half the rate of bit k-1,
  // so each tap is exactly 50% duty with no compare glitch.
  always_comb begin
    next_count = count;
    if (vco_rise) begin
      next_count = count + OUT_ONE;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= '0;
      vco_d <= 1'b0;
    end else begin
      count <= next_count;
      vco_d <= vco_in;
    end
  end

  // Divide by one passes the VCO level, which keeps its even duty cycle.
  always_comb begin
    case (n_sel_in)
      2'h0:    div_out = vco_in;
      2'h1:    div_out = count[0];
      2'h2:    div_out = count[1];
      default: div_out = count[2];
    endcase
  end

endmodule : pdcl_out_div

// ==== testbench/pdcl_host_model.sv ====
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// Host model driving the parallel and serial configuration pins.
// ---------------------------------------------------------------------
module pdcl_host_model
  import pdcl_pkg::*;
(
  input  wire logic      clk_in,
  output logic           par_load_n_out,
  output logic [M_W-1:0] m_par_out,
  output logic [N_W-1:0] n_par_out,
  output logic           ser_clock_out,
  output logic           ser_data_out,
  output logic           ser_load_out
);
  // Strobe starts low so reset passes with the parallel path in charge.
  initial begin
    par_load_n_out = 1'b0;
    m_par_out      = 9'h0C8;
    n_par_out      = 2'h0;
    ser_clock_out  = 1'b0;
    ser_data_out   = 1'b0;
    ser_load_out   = 1'b0;
  end

  // Four clocks a level, since the pin filter needs two to settle.
  task automatic hold4();
    repeat (4) @(posedge clk_in);
    #10;
  endtask : hold4

  // Sets strobe and parallel inputs together and keeps them eight clocks.
  task automatic par_pins(input logic           low_n,
                          input logic [M_W-1:0] m,
                          input logic [N_W-1:0] n);
    par_load_n_out = low_n;
    m_par_out      = m;
    n_par_out      = n;
    hold4();
    hold4();
  endtask : par_pins

  // Sends the nb low bits of w, most significant first, one per serial clock pulse, eight clocks each.
  task automatic ser_send(input logic [15:0] w, input int nb);
    for (int i = nb - 1; i >= 0; i--) begin
      ser_data_out  = w[i];
      hold4();
      ser_clock_out = 1'b1;
      hold4();
      ser_clock_out = 1'b0;
    end
    // Released data shows the opposite level, never a stale copy.
    ser_data_out = ~ser_data_out;
  endtask : ser_send

  // Load pulse; the falling edge is what the device acts on.
  task automatic ser_pulse();
    ser_load_out = 1'b1;
    hold4();
    ser_load_out = 1'b0;
    hold4();
    hold4();
  endtask : ser_pulse
endmodule : pdcl_host_model

// ==== testbench/tb_pll_divider_config_loader.sv ====
`timescale 1ns/1ps
module tb_pll_divider_config_loader
  import pdcl_pkg::*;
;
  logic           clk_in;
  logic           reset_n_in;
  logic           xtal_in;
  logic           vco_in;
  logic           par_load_n;
  logic [M_W-1:0] m_par;
  logic [N_W-1:0] n_par;
  logic           ser_clock;
  logic           ser_data;
  logic           ser_load;
  logic           ref_clk_out;
  logic           fb_clk_out;
  logic [3:0]     osc_phase;
  logic           synth_clock_out;
  logic           probe_out;
  logic [M_W-1:0] m_cfg_out;
  logic [N_W-1:0] n_cfg_out;
  logic [T_W-1:0] t_cfg_out;
  int             err_count;
  int             checks_done;
  int             ref_rises;
  int             synth_rises;
  int             fb_pulses;

  pdcl_loader DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .xtal_in(xtal_in), .vco_in(vco_in), .par_load_n_in(par_load_n),
    .m_par_in(m_par), .n_par_in(n_par), .ser_clock_in(ser_clock),
    .ser_data_in(ser_data), .ser_load_in(ser_load),
    .ref_clk_out(ref_clk_out), .fb_clk_out(fb_clk_out),
    .probe_out(probe_out),
    .synth_clock_out(synth_clock_out), .m_cfg_out(m_cfg_out),
    .n_cfg_out(n_cfg_out), .t_cfg_out(t_cfg_out));

  pdcl_host_model host (.clk_in(clk_in), .par_load_n_out(par_load_n),
    .m_par_out(m_par), .n_par_out(n_par), .ser_clock_out(ser_clock),
    .ser_data_out(ser_data), .ser_load_out(ser_load));

  // ---------------------------------------------------------------------
  // Clock, sampled oscillators and edge counters.
  // ---------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // The VCO holds each level four clocks and the crystal eight, since the
  // pin filter loses any level that is shorter than two clocks.
  always @(posedge clk_in) begin
    #10;
    osc_phase = osc_phase + 4'h1;
    vco_in    = osc_phase[2];
    xtal_in   = osc_phase[3];
  end

  // Counting rises is coarse, so the rate checks allow one off.
  always @(posedge ref_clk_out) ref_rises++;
  always @(posedge synth_clock_out) synth_rises++;
  always @(posedge fb_clk_out) fb_pulses++;

  // ---------------------------------------------------------------------
  // Check and closing tasks.
  // ---------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got, input int tol);
    checks_done++;
    if ((got >= exp - tol && got <= exp + tol) !== 1'b1) begin
      err_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Watchdog: the tests need about thirteen thousand clocks.
  initial begin
    #2_000_000;
    err_count++;
    summarize();
  end

  // ---------------------------------------------------------------------
  // Test sequence.
  // ---------------------------------------------------------------------
  initial begin
    reset_n_in = 1'b0;
    xtal_in    = 1'b0;
    vco_in     = 1'b0;
    osc_phase  = 4'h0;
    repeat (8) @(posedge clk_in);
    #10 reset_n_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #10;
    chk("m reset", M_RESET, m_cfg_out, 0);
    chk("t reset", T_STATIC, t_cfg_out, 0);
    host.par_pins(1'b0, 9'h106, 2'h1);
    chk("m track", 9'h106, m_cfg_out, 0);
    chk("n track", 2'h1, n_cfg_out, 0);
    host.par_pins(1'b1, 9'h106, 2'h1);
    host.par_pins(1'b1, 9'h0D2, 2'h2);
    chk("m held", 9'h106, m_cfg_out, 0);
    chk("n held", 2'h1, n_cfg_out, 0);
    host.ser_send({2'h0, 3'h4, 2'h2, 9'h12C}, 14);
    chk("m before load", 9'h106, m_cfg_out, 0);
    host.ser_pulse();
    chk("m serial", 9'h12C, m_cfg_out, 0);
    chk("n serial", 2'h2, n_cfg_out, 0);
    chk("t serial", 3'h4, t_cfg_out, 0);
    chk("probe high", 1'b1, probe_out, 0);
    host.ser_send({2'h3, 3'h1, 2'h3, 9'h190}, 16);
    host.ser_pulse();
    chk("m last bits", 9'h190, m_cfg_out, 0);
    chk("n last bits", 2'h3, n_cfg_out, 0);
    chk("t last bits", 3'h1, t_cfg_out, 0);
    host.par_pins(1'b0, 9'h0FA, 2'h0);
    chk("t forced", 3'h0, t_cfg_out, 0);
    chk("probe static", 1'b0, probe_out, 0);
    host.ser_send({2'h0, 3'h7, 2'h3, 9'h15E}, 14);
    host.ser_pulse();
    chk("m parallel wins", 9'h0FA, m_cfg_out, 0);
    chk("n parallel wins", 2'h0, n_cfg_out, 0);
    chk("t parallel wins", 3'h0, t_cfg_out, 0);
    // Every output divide code, VCO rising every eighth clock.
    for (int n = 0; n < 4; n++) begin
      host.par_pins(1'b0, 9'h0C8, n[1:0]);
      synth_rises = 0;
      repeat (1600) @(posedge clk_in);
      #10;
      chk("synth rises", 16'(200 >> n), 16'(synth_rises), 1);
    end
    // 800 VCO rises at M of 200 and 400 crystal rises over 16.
    ref_rises = 0;
    fb_pulses = 0;
    repeat (6400) @(posedge clk_in);
    #10;
    chk("ref rises", 16'h0019, 16'(ref_rises), 1);
    chk("fb pulses", 16'h0004, 16'(fb_pulses), 1);
    summarize();
  end
endmodule : tb_pll_divider_config_loader
